// ==== gdl_loop_cfg_regs.sv ====
// loop configuration register bank for the delay-reduction and slew-time loops
//
// What this block does
// - register 33h, reset 11h, high nibble pair 1-2, low nibble pair 3-4.
// - register 34h, reset 11h, high nibble pair 5-6, low nibble pair 7-8.
// - nibble top bit enables the delay loop of its pair; resets off.
// - nibble bit 2 picks error mode: zero one-bit, one actual; resets zero.
// - nibble gain field codes 00..11 give gains 1..4; resets 01b.
// - register 35h, reset 23h, slew loop configuration of pair 1-2.
// - slew bits 7-4 select transition time, codes 0..7 0.35..2.45 us; reset 0010b.
// - codes 1000b..1111b except 1011b give 2.94 through 15.96 us.
// - code 1011b selects 5.95 us.
// - slew bit 3 enables the slew loop of pair 1-2; resets off.
// - slew bit 2 picks error mode: zero one-bit, one actual; resets zero.
// - slew gain field codes 00..11 give gains 1..4; resets 11b.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "gdl_defines.svh"

module gdl_loop_cfg_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`GDL_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // delay-reduction loops, index 0 = pair 1-2 ... index 3 = pair 7-8
  output logic [3:0] delay_loop_enable_o,
  output logic [3:0] delay_loop_error_mode_o,
  output logic [7:0] delay_loop_gain_code_o,
  output logic [11:0] delay_loop_gain_o,
  // slew-time loop of pair 1-2
  output logic slew_loop_enable_pair_1_2_o,
  output logic slew_loop_error_mode_pair_1_2_o,
  output logic [1:0] slew_loop_gain_code_pair_1_2_o,
  output logic [2:0] slew_loop_gain_pair_1_2_o,
  output logic [3:0] slew_time_code_pair_1_2_o,
  output logic [13:0] slew_time_ns_pair_1_2_o,
  // one-cycle strobe per register after a write, so loops can reload
  output logic [2:0] cfg_update_o
);

  gdl_reg_if rif ();

  gdl_pkg::gdl_byte_t dly_q [`GDL_DLY_REGS];
  gdl_pkg::gdl_byte_t dly_d [`GDL_DLY_REGS];
  gdl_pkg::gdl_byte_t slew_q, slew_d;
  logic [2:0] upd_q, upd_d;
  gdl_pkg::gdl_time_ns_t tt_ns_q, tt_ns_d;
  gdl_pkg::gdl_gain_t slew_gain_q, slew_gain_d;
  logic [13:0] tt_lut_ns;
  logic wr_dly_a, wr_dly_b, wr_slew;

  gdl_wb_slave u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rif(rif.bus)
  );

  // address decode
  assign wr_dly_a = rif.wr_stb & (rif.idx == `GDL_IDX_DLY_1_TO_4);
  assign wr_dly_b = rif.wr_stb & (rif.idx == `GDL_IDX_DLY_5_TO_8);
  assign wr_slew = rif.wr_stb & (rif.idx == `GDL_IDX_SLEW_1_2);

  // read mux; all three registers read back what was written, full byte
  always_comb
  begin
    rif.hit = 1'b1;
    case (rif.idx)
      `GDL_IDX_DLY_1_TO_4: rif.rdata = dly_q[0];
      `GDL_IDX_DLY_5_TO_8: rif.rdata = dly_q[1];
      `GDL_IDX_SLEW_1_2: rif.rdata = slew_q;
      default:
      begin
        rif.rdata = 8'h00;
        rif.hit = 1'b0;
      end
    endcase
  end

  // register next values
  always_comb
  begin
    dly_d[0] = dly_q[0];
    dly_d[1] = dly_q[1];
    slew_d = slew_q;
    if (wr_dly_a)
      dly_d[0] = rif.wdata;
    if (wr_dly_b)
      dly_d[1] = rif.wdata;
    if (wr_slew)
      slew_d = rif.wdata;
  end

  // reset values give: loops off, one-bit error, delay gain 2, slew gain 4, 0.77 us
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dly_q[0] <= `GDL_RST_DLY;
      dly_q[1] <= `GDL_RST_DLY;
      slew_q <= `GDL_RST_SLEW;
    end
    else
    begin
      dly_q[0] <= dly_d[0];
      dly_q[1] <= dly_d[1];
      slew_q <= slew_d;
    end
  end

  // update strobes follow the write by one edge, when raw field outputs show it; decoded gain and time lag one more edge
  always_comb
  begin
    upd_d = 3'h0;
    upd_d[`GDL_UPD_DLY_1_TO_4] = wr_dly_a;
    upd_d[`GDL_UPD_DLY_5_TO_8] = wr_dly_b;
    upd_d[`GDL_UPD_SLEW_1_2] = wr_slew;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      upd_q <= 3'h0;
    else
      upd_q <= upd_d;
  end

  assign cfg_update_o = upd_q;

  // per-pair field extraction; even pairs take the high nibble of their register
  genvar p;
  generate
    for (p = 0; p < `GDL_DLY_PAIRS; p++)
    begin : g_pair
      logic [`GDL_NIB_W-1:0] nib;
      gdl_pkg::gdl_gain_t gain_q, gain_d;

      if ((p % 2) == 0)
      begin : g_hi
        assign nib = dly_q[p/2][`GDL_NIB_W +: `GDL_NIB_W];
      end
      else
      begin : g_lo
        assign nib = dly_q[p/2][0 +: `GDL_NIB_W];
      end

      assign delay_loop_enable_o[p] = nib[`GDL_NIB_EN];
      assign delay_loop_error_mode_o[p] = nib[`GDL_NIB_ERR];
      assign delay_loop_gain_code_o[2*p+1:2*p] = nib[`GDL_NIB_GAIN_HI:`GDL_NIB_GAIN_LO];

      // decoded gain is registered so it arrives one edge after the code
      always_comb
      begin
        gain_d = 3'(nib[`GDL_NIB_GAIN_HI:`GDL_NIB_GAIN_LO]) + `GDL_GAIN_BASE;
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          gain_q <= 3'(`GDL_RST_DLY_GAIN) + `GDL_GAIN_BASE;
        else
          gain_q <= gain_d;
      end

      assign delay_loop_gain_o[3*p+2:3*p] = gain_q;
    end
  endgenerate

  // slew-time loop fields
  assign slew_loop_enable_pair_1_2_o = slew_q[`GDL_SLEW_EN];
  assign slew_loop_error_mode_pair_1_2_o = slew_q[`GDL_SLEW_ERR];
  assign slew_loop_gain_code_pair_1_2_o = slew_q[`GDL_SLEW_GAIN_HI:`GDL_SLEW_GAIN_LO];
  assign slew_time_code_pair_1_2_o = slew_q[`GDL_SLEW_TT_HI:`GDL_SLEW_TT_LO];

  gdl_slew_time_lut u_tt (
    .code_i(slew_q[`GDL_SLEW_TT_HI:`GDL_SLEW_TT_LO]),
    .time_ns_o(tt_lut_ns)
  );

  // decoded time and gain are registered, one edge behind the raw fields
  always_comb
  begin
    tt_ns_d = tt_lut_ns;
    slew_gain_d = 3'(slew_q[`GDL_SLEW_GAIN_HI:`GDL_SLEW_GAIN_LO]) + `GDL_GAIN_BASE;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tt_ns_q <= gdl_pkg::GDL_TT_NS[`GDL_RST_SLEW_TT];
      slew_gain_q <= 3'(`GDL_RST_SLEW_GAIN) + `GDL_GAIN_BASE;
    end
    else
    begin
      tt_ns_q <= tt_ns_d;
      slew_gain_q <= slew_gain_d;
    end
  end

  assign slew_time_ns_pair_1_2_o = tt_ns_q;
  assign slew_loop_gain_pair_1_2_o = slew_gain_q;

endmodule // gdl_loop_cfg_regs

// ==== gdl_defines.svh ====
// register indices, reset values, field positions and codes of the loop configuration bank
`ifndef GDL_DEFINES_SVH
`define GDL_DEFINES_SVH

// register indices; the wishbone byte address is four times the index
`define GDL_IDX_DLY_1_TO_4 6'h33
`define GDL_IDX_DLY_5_TO_8 6'h34
`define GDL_IDX_SLEW_1_2 6'h35
`define GDL_IDX_W 6
`define GDL_ADR_W 8
`define GDL_ADR_IDX_HI 7
`define GDL_ADR_IDX_LO 2
`define GDL_ADR_ALIGN_HI 1
`define GDL_ALIGN_OK 2'h0

// reset values
`define GDL_RST_DLY 8'h11
`define GDL_RST_SLEW 8'h23
// field reset values, kept in step with the register resets above
`define GDL_RST_DLY_GAIN 2'h1
`define GDL_RST_SLEW_GAIN 2'h3
`define GDL_RST_SLEW_TT 4'h2

// delay-loop nibble layout, relative to the nibble
`define GDL_NIB_W 4
`define GDL_NIB_EN 3
`define GDL_NIB_ERR 2
`define GDL_NIB_GAIN_HI 1
`define GDL_NIB_GAIN_LO 0
`define GDL_DLY_REGS 2
`define GDL_DLY_PAIRS 4

// slew register layout
`define GDL_SLEW_TT_HI 7
`define GDL_SLEW_TT_LO 4
`define GDL_SLEW_EN 3
`define GDL_SLEW_ERR 2
`define GDL_SLEW_GAIN_HI 1
`define GDL_SLEW_GAIN_LO 0

// gain code 00..11 means gain 1..4
`define GDL_GAIN_BASE 3'h1

// number of registers in the bank, for the update strobes
`define GDL_NUM_REGS 3
`define GDL_UPD_DLY_1_TO_4 0
`define GDL_UPD_DLY_5_TO_8 1
`define GDL_UPD_SLEW_1_2 2

`endif

// ==== gdl_pkg.sv ====
// types and transition-time table of the loop configuration bank
package gdl_pkg;

  typedef logic [7:0] gdl_byte_t;
  typedef logic [1:0] gdl_gain_code_t;
  typedef logic [2:0] gdl_gain_t;
  typedef logic [3:0] gdl_tt_code_t;
  typedef logic [13:0] gdl_time_ns_t;

  // bus-slave states, one-hot
  typedef enum logic [1:0] {
    GDL_ST_IDLE = 2'h1,
    GDL_ST_ACK = 2'h2
  } gdl_state_e;

  // error-limit mode of a loop
  typedef enum logic {
    GDL_ERR_ONE_BIT = 1'h0,
    GDL_ERR_ACTUAL = 1'h1
  } gdl_err_mode_e;

  // target switch-node transition time in ns, indexed by code
  localparam gdl_time_ns_t GDL_TT_NS [16] = '{
    14'h015E, 14'h0230, 14'h0302, 14'h03D4, 14'h0532, 14'h0690, 14'h07EE, 14'h0992,
    14'h0B7C, 14'h0F96, 14'h136A, 14'h173E, 14'h1F2C, 14'h26D4, 14'h2EC2, 14'h3E58
  };

endpackage

// ==== gdl_reg_if.sv ====
// carrier between the wishbone slave and the register bank
`timescale 1ns/1ps
`include "gdl_defines.svh"

interface gdl_reg_if;
  logic wr_stb;
  logic [`GDL_IDX_W-1:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;

  modport bus (
    output wr_stb,
    output idx,
    output wdata,
    input rdata,
    input hit
  );

  modport bank (
    input wr_stb,
    input idx,
    input wdata,
    output rdata,
    output hit
  );
endinterface

// ==== gdl_wb_slave.sv ====
// classic wishbone slave: one wait state, registered read data
`timescale 1ns/1ps
`include "gdl_defines.svh"

module gdl_wb_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`GDL_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  gdl_reg_if.bus rif
);

  gdl_pkg::gdl_state_e state_q, state_d;
  logic [31:0] dat_q, dat_d;
  logic req;
  logic aligned;

  assign req = wb_cyc_i & wb_stb_i;
  assign aligned = (wb_adr_i[`GDL_ADR_ALIGN_HI:0] == `GDL_ALIGN_OK);
  assign rif.idx = wb_adr_i[`GDL_ADR_IDX_HI:`GDL_ADR_IDX_LO];
  assign rif.wdata = wb_dat_i[7:0];
  // write lands on the edge where the master sees ack; only lane 0 carries data
  assign rif.wr_stb = (state_q == gdl_pkg::GDL_ST_ACK) & req & wb_we_i & wb_sel_i[0]
                      & aligned & rif.hit;
  assign wb_ack_o = (state_q == gdl_pkg::GDL_ST_ACK);
  assign wb_dat_o = dat_q;

  always_comb
  begin
    state_d = state_q;
    dat_d = dat_q;
    case (state_q)
      gdl_pkg::GDL_ST_IDLE:
      begin
        if (req)
        begin
          state_d = gdl_pkg::GDL_ST_ACK;
          // unmapped or misaligned reads return zero and are still acked
          dat_d = (rif.hit & aligned & ~wb_we_i) ? {24'h000000, rif.rdata} : 32'h00000000;
        end
      end
      gdl_pkg::GDL_ST_ACK:
        state_d = gdl_pkg::GDL_ST_IDLE;
      default:
        state_d = gdl_pkg::GDL_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= gdl_pkg::GDL_ST_IDLE;
      dat_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      dat_q <= dat_d;
    end
  end

endmodule // gdl_wb_slave

// ==== gdl_slew_time_lut.sv ====
// transition-time code to target time in ns
`timescale 1ns/1ps

module gdl_slew_time_lut (
  input wire logic [3:0] code_i,
  output logic [13:0] time_ns_o
);

  // all sixteen codes are defined, so no fallback value is needed
  assign time_ns_o = gdl_pkg::GDL_TT_NS[code_i];

endmodule // gdl_slew_time_lut

// ==== gdl_loop_cfg_regs_sva.sv ====
// assertion checker for the loop configuration bank
`timescale 1ns/1ps
module gdl_loop_cfg_regs_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0] delay_loop_enable_o,
  input wire logic [3:0] delay_loop_error_mode_o,
  input wire logic [7:0] delay_loop_gain_code_o,
  input wire logic [11:0] delay_loop_gain_o,
  input wire logic slew_loop_enable_pair_1_2_o,
  input wire logic slew_loop_error_mode_pair_1_2_o,
  input wire logic [1:0] slew_loop_gain_code_pair_1_2_o,
  input wire logic [2:0] slew_loop_gain_pair_1_2_o,
  input wire logic [3:0] slew_time_code_pair_1_2_o,
  input wire logic [2:0] cfg_update_o
);
  logic wr;
  logic [3:0] en, em;
  logic [7:0] gc, slew, dly0, dly1;
  // write lands only at the ack edge, while the master still holds stb
  assign wr = wb_ack_o && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign en = delay_loop_enable_o;
  assign em = delay_loop_error_mode_o;
  assign gc = delay_loop_gain_code_o;
  assign slew = {slew_time_code_pair_1_2_o, slew_loop_enable_pair_1_2_o,
    slew_loop_error_mode_pair_1_2_o, slew_loop_gain_code_pair_1_2_o};
  assign dly0 = {en[0], em[0], gc[1:0], en[1], em[1], gc[3:2]};
  assign dly1 = {en[2], em[2], gc[5:4], en[3], em[3], gc[7:6]};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dly_lo_write: assert property (wr && wb_adr_i == 8'hCC |=> dly0 == $past(wb_dat_i[7:0]))
    else $error("reg 33 write");
  a_dly_hi_write: assert property (wr && wb_adr_i == 8'hD0 |=> dly1 == $past(wb_dat_i[7:0]))
    else $error("reg 34 write");
  a_slew_write: assert property (wr && wb_adr_i == 8'hD4 |=> slew == $past(wb_dat_i[7:0]))
    else $error("reg 35 write");
  a_slew_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hD4 |-> wb_dat_o == {24'h0, slew})
    else $error("reg 35 read");
  a_cfg_hold: assert property (!wr |=> $stable({slew, dly0, dly1}))
    else $error("config moved");
  a_dly_gain_map: assert property (delay_loop_gain_o[2:0] == $past(gc[1:0]) + 3'h1)
    else $error("delay gain");
  a_slew_gain_map: assert property (slew_loop_gain_pair_1_2_o == $past(slew[1:0]) + 3'h1)
    else $error("slew gain");
  a_update_pulse: assert property (cfg_update_o[2] == $past(wr && wb_adr_i == 8'hD4))
    else $error("update strobe");
endmodule // gdl_loop_cfg_regs_sva

bind gdl_loop_cfg_regs gdl_loop_cfg_regs_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .delay_loop_enable_o,
  .delay_loop_error_mode_o, .delay_loop_gain_code_o, .delay_loop_gain_o,
  .slew_loop_enable_pair_1_2_o, .slew_loop_error_mode_pair_1_2_o,
  .slew_loop_gain_code_pair_1_2_o, .slew_loop_gain_pair_1_2_o, .slew_time_code_pair_1_2_o,
  .cfg_update_o);

// ==== tb.sv ====
// self-checking bench for the loop configuration bank
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, sen, sem;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  logic [3:0] en, em, slew_time_control_loop;
  logic [7:0] gc;
  logic [11:0] g;
  logic [1:0] sgc;
  logic [2:0] sg, upd;
  logic [13:0] sns;
  int errors = 0;
  int total_checks = 0;
  int tt [16] = '{350, 560, 770, 980, 1330, 1680, 2030, 2450,
    2940, 3990, 4970, 5950, 7980, 9940, 11970, 15960};
  always #20 clk_i = ~clk_i;
  gdl_loop_cfg_regs uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .delay_loop_enable_o(en), .delay_loop_error_mode_o(em), .delay_loop_gain_code_o(gc),
    .delay_loop_gain_o(g), .slew_loop_enable_pair_1_2_o(sen),
    .slew_loop_error_mode_pair_1_2_o(sem), .slew_loop_gain_code_pair_1_2_o(sgc),
    .slew_loop_gain_pair_1_2_o(sg), .slew_time_code_pair_1_2_o(slew_time_control_loop),
    .slew_time_ns_pair_1_2_o(sns), .cfg_update_o(upd));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // two idle edges after ack: strobe seen, decoded outputs settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= a;
    sel <= s;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
    chk("update", {3{s[0]}} & {a == 8'hD4, a == 8'hD0, a == 8'hCC}, upd);
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b0;
    adr <= a;
    sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    chk("read", e, rd);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_reset;
    rdc(8'hCC, 32'h11);
    rdc(8'hD0, 32'h11);
    rdc(8'hD4, 32'h23);
    chk("enables", 5'h0, {sen, en});
    chk("modes", 5'h0, {sem, em});
    chk("dly gains", {8'h55, 12'h492}, {gc, g});
    chk("slew", {4'h2, 2'h3, 3'h4, 14'h0302}, {slew_time_control_loop, sgc, sg, sns});
  endtask
  // reset in mid-run must bring every field and decoded output back to its reset value
  task automatic t_rst_mid;
    wr(8'hD4, 8'hFF, 4'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset flags", 10'h000, {sen, sem, en, em});
    chk("reset dly", {8'h55, 12'h492}, {gc, g});
    chk("reset slew", {4'h2, 2'h3, 3'h4, 14'h0302}, {slew_time_control_loop, sgc, sg, sns});
    chk("reset rd", 32'h0, rd);
    rdc(8'hCC, 32'h11);
    rdc(8'hD4, 32'h23);
  endtask
  task automatic t_delay;
    for (int k = 0; k < 4; k++)
    begin
      wr(8'hCC, {2'b10, 2'(k), 2'b01, 2'(k)}, 4'h1);
      wr(8'hD0, {2'b01, 2'(k), 2'b10, 2'(k)}, 4'h1);
      chk("dly en", 4'b1001, en);
      chk("dly mode", 4'b0110, em);
      chk("dly code", {4{2'(k)}}, gc);
      chk("dly gain", {4{3'(k + 1)}}, g);
      rdc(8'hD0, {2'b01, 2'(k), 2'b10, 2'(k)});
    end
  endtask
  // refused writes must leave the last pattern intact
  task automatic t_refuse;
    wr(8'hCC, 8'h00, 4'hE);
    wr(8'hCD, 8'h00, 4'h1);
    wr(8'hD8, 8'h00, 4'h1);
    rdc(8'hCC, 32'hB7);
    rdc(8'hD8, 32'h0);
  endtask
  task automatic t_slew;
    logic [7:0] d;
    for (int c = 0; c < 16; c++)
    begin
      d = {4'(c), 4'(c)};
      wr(8'hD4, d, 4'h1);
      chk("slew ns", tt[c], sns);
      chk("slew fields", d, {slew_time_control_loop, sen, sem, sgc});
      chk("slew gain", c % 4 + 1, sg);
      rdc(8'hD4, d);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_delay;
    t_refuse;
    t_slew;
    t_rst_mid;
    wrap_up;
  end
  // whole run is a few hundred cycles; this only cuts a hung handshake
  initial
  begin
    #100000;
    errors++;
    wrap_up;
  end
endmodule // tb
